// file: twcw_pkg.sv
package twcw_pkg;
    // Register file shape.
    localparam int          TWCW_NUM_REGS   = 7;
    localparam int          TWCW_ADDR_W     = 3;
    localparam int          TWCW_BYTE_W     = 8;
    localparam int          TWCW_BIT_CNT_W  = 3;
    localparam logic [2:0]  TWCW_LAST_BIT   = 3'h7;
    localparam logic [2:0]  TWCW_ADDR_VMC   = 3'h0;
    localparam logic [2:0]  TWCW_ADDR_LAST  = 3'h6;
    localparam int          TWCW_SEL_BIT    = 0;
    // Reset value of every register and of the control byte.
    localparam logic [7:0]  TWCW_REG_RST    = 8'h00;
    localparam logic [7:0]  TWCW_VMC_RST    = 8'h03;
    // Hard reset timing.
    localparam int          TWCW_RST_US     = 10;
    localparam int          TWCW_CLK_MHZ    = 250;
    localparam int          TWCW_RST_CYC    = TWCW_RST_US * TWCW_CLK_MHZ;
    // Shift clock divider: half period in host clocks.
    localparam int          TWCW_HALF_DIV   = 15;
    localparam int          TWCW_DIV_W      = 5;
    localparam int          TWCW_RCNT_W     = 16;
    localparam int          TWCW_BCNT_W     = 6;
    localparam logic [5:0]  TWCW_MAX_BYTES  = 6'h07;
endpackage : twcw_pkg

// file: twcw_if.sv
`timescale 1ns/1ps
interface twcw_if;
    logic shift_clk;
    logic load_strobe_n;
    logic serial_data_in;
    logic reg_rst_n;

    modport dev  (input shift_clk, input load_strobe_n, input serial_data_in, input reg_rst_n);
    modport host (output shift_clk, output load_strobe_n, output serial_data_in,
                  output reg_rst_n);
endinterface : twcw_if

// file: twcw_dev.sv
`timescale 1ns/1ps
//
// Contract
// [RL1] Registers reached only through three serial wires.
// [RL2] Eight bits per register, LSB first.
// [RL3] Capture data on shift clock rise while strobe low.
// [RL4] Latch byte on strobe rise after MSB.
// [RL5] Writes start at address 00, successive addresses.
// [RL6] Host always sends address 00 byte first.
// [RL7] Variant bit high required for register writes.
// [RL8] Registers clear while reset pin is low; address 00 resets to 03 instead.
// [RL9] Host applies hard reset after power-up.
// [RL10] Host keeps serial lines at defined levels.
// [RL11] Reset pin active low, resets registers only.
// [RL12] Strobe high ignores shift clock edges.
module twcw_dev
    import twcw_pkg::*;
(
    // Link side.
    twcw_if.dev                    link,
    // Register contents, user side.
    output logic [TWCW_BYTE_W-1:0] reg_q [TWCW_NUM_REGS]
);

    logic [TWCW_BYTE_W-1:0]    shift_r;
    logic [TWCW_BIT_CNT_W-1:0] bit_r;
    logic [TWCW_ADDR_W-1:0]    addr_r;
    logic                      frame_tog_r;
    logic                      seen_tog_r;
    logic                      sel_ok_r;
    logic [TWCW_BYTE_W-1:0]    stage_r [TWCW_NUM_REGS];
    logic [TWCW_NUM_REGS-1:0]  stage_v_r;
    logic                      rst_a;

    // The reset pin is active low; it resets only the register path.
    assign rst_a = ~link.reg_rst_n; // [RL11]

    // Shift bits in LSB first on shift clock rise while the strobe is low.
    // A toggle from the strobe domain marks each finished frame; it settles long
    // before the next frame's first shift clock rise, so no edge while the
    // strobe is high is needed to restart the shift state.
    always_ff @(posedge link.shift_clk or posedge rst_a) begin
        if (rst_a) begin
            shift_r    <= TWCW_REG_RST;
            bit_r      <= '0;
            addr_r     <= TWCW_ADDR_VMC;
            seen_tog_r <= 1'b0;
            sel_ok_r   <= 1'b0;
            stage_v_r  <= '0;
            for (int i = 0; i < TWCW_NUM_REGS; i++) begin
                stage_r[i] <= TWCW_REG_RST;
            end
        end else if (!link.load_strobe_n) begin // [RL3] [RL12]
            if (frame_tog_r != seen_tog_r) begin
                // First bit of a new frame restarts at address 00.
                seen_tog_r <= frame_tog_r;
                stage_v_r  <= '0;
                sel_ok_r   <= 1'b0;
                addr_r     <= TWCW_ADDR_VMC; // [RL5] [RL6]
                bit_r      <= TWCW_BIT_CNT_W'(1);
                shift_r    <= {link.serial_data_in, (TWCW_BYTE_W-1)'(0)};
            end else begin
                shift_r <= {link.serial_data_in, shift_r[TWCW_BYTE_W-1:1]}; // [RL2]
                bit_r   <= bit_r + TWCW_BIT_CNT_W'(1);
                if (bit_r == TWCW_LAST_BIT) begin
                    // Complete byte is staged for the strobe rise.
                    stage_r[addr_r]   <= {link.serial_data_in, shift_r[TWCW_BYTE_W-1:1]};
                    stage_v_r[addr_r] <= 1'b1;
                    if (addr_r == TWCW_ADDR_VMC) begin
                        sel_ok_r <= shift_r[TWCW_SEL_BIT+1]; // [RL7]
                    end
                    if (addr_r != TWCW_ADDR_LAST) begin
                        addr_r <= addr_r + TWCW_ADDR_W'(1); // [RL5]
                    end
                end
            end
        end
    end

    // Commit staged bytes on the strobe rise, only with the variant bit set.
    // Every strobe rise also flips the frame toggle read by the shift logic.
    always_ff @(posedge link.load_strobe_n or posedge rst_a) begin
        if (rst_a) begin
            frame_tog_r <= 1'b0;
            for (int i = 0; i < TWCW_NUM_REGS; i++) begin
                reg_q[i] <= (i == 0) ? TWCW_VMC_RST : TWCW_REG_RST; // [RL8]
            end
        end else begin
            frame_tog_r <= ~frame_tog_r;
            if (sel_ok_r && bit_r == '0) begin // [RL4] [RL7]
                for (int i = 0; i < TWCW_NUM_REGS; i++) begin
                    if (stage_v_r[i]) begin
                        reg_q[i] <= stage_r[i]; // [RL1]
                    end
                end
            end
        end
    end

endmodule : twcw_dev

// file: twcw_host.sv
`timescale 1ns/1ps
module twcw_host
    import twcw_pkg::*;
(
    // Clock and reset.
    input  logic                   clock,
    input  logic                   rst,
    // Link side.
    twcw_if.host                   link,
    // Command side.
    input  logic                   cmd_reset,
    input  logic                   cmd_write,
    input  logic [TWCW_BCNT_W-1:0] cmd_nbytes,
    input  logic [TWCW_BYTE_W-1:0] cmd_data [TWCW_NUM_REGS],
    output logic                   busy_r
);

    typedef enum {TWCW_IDLE, TWCW_HRST, TWCW_LOW, TWCW_HIGH, TWCW_END} twcw_st_t;

    twcw_st_t               st_r;
    logic [TWCW_RCNT_W-1:0] cnt_r;
    logic [TWCW_BCNT_W-1:0] nb_r;
    logic [TWCW_BCNT_W-1:0] byte_r;
    logic [2:0]             bit_r;
    logic [TWCW_BYTE_W-1:0] data_r [TWCW_NUM_REGS];
    logic                   sck_r;
    logic                   sl_r;
    logic                   sd_r;
    logic                   rn_r;

    assign link.shift_clk      = sck_r;
    assign link.load_strobe_n  = sl_r;
    assign link.serial_data_in = sd_r;
    assign link.reg_rst_n      = rn_r;

    // Sequencer: hard reset, then frames starting at address 00, LSB first.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_r   <= TWCW_IDLE;
            cnt_r  <= '0;
            nb_r   <= '0;
            byte_r <= '0;
            bit_r  <= '0;
            sck_r  <= 1'b0;
            sl_r   <= 1'b1; // [RL10]
            sd_r   <= 1'b0;
            rn_r   <= 1'b0; // [RL9]
            busy_r <= 1'b1;
            for (int i = 0; i < TWCW_NUM_REGS; i++) begin
                data_r[i] <= TWCW_REG_RST;
            end
        end else begin
            case (st_r)
                TWCW_IDLE: begin
                    if (!rn_r || cmd_reset) begin
                        rn_r   <= 1'b0;
                        cnt_r  <= '0;
                        busy_r <= 1'b1;
                        st_r   <= TWCW_HRST;
                    end else if (cmd_write && cmd_nbytes != '0) begin
                        data_r <= cmd_data;
                        data_r[0][TWCW_SEL_BIT] <= 1'b1; // [RL7]
                        nb_r   <= (cmd_nbytes > TWCW_MAX_BYTES) ? TWCW_MAX_BYTES : cmd_nbytes;
                        byte_r <= '0; // [RL6]
                        bit_r  <= '0;
                        cnt_r  <= '0;
                        sl_r   <= 1'b0;
                        busy_r <= 1'b1;
                        st_r   <= TWCW_LOW;
                    end else begin
                        busy_r <= 1'b0;
                    end
                end
                TWCW_HRST: begin
                    // Hold reset low for the minimum hard reset time.
                    cnt_r <= cnt_r + TWCW_RCNT_W'(1);
                    if (cnt_r == TWCW_RCNT_W'(TWCW_RST_CYC - 1)) begin // [RL8]
                        rn_r <= 1'b1;
                        st_r <= TWCW_IDLE;
                    end
                end
                TWCW_LOW: begin
                    // Clock edges fall on state changes so both halves are equal.
                    sd_r  <= data_r[byte_r[TWCW_ADDR_W-1:0]][bit_r]; // [RL2]
                    cnt_r <= cnt_r + TWCW_RCNT_W'(1);
                    if (cnt_r == TWCW_RCNT_W'(TWCW_HALF_DIV - 1)) begin
                        cnt_r <= '0;
                        sck_r <= 1'b1;
                        st_r  <= TWCW_HIGH;
                    end
                end
                TWCW_HIGH: begin
                    cnt_r <= cnt_r + TWCW_RCNT_W'(1);
                    if (cnt_r == TWCW_RCNT_W'(TWCW_HALF_DIV - 1)) begin
                        cnt_r <= '0;
                        sck_r <= 1'b0;
                        bit_r <= bit_r + 3'h1;
                        if (bit_r == TWCW_LAST_BIT) begin
                            byte_r <= byte_r + TWCW_BCNT_W'(1); // [RL5]
                            st_r   <= (byte_r + TWCW_BCNT_W'(1) == nb_r) ? TWCW_END : TWCW_LOW;
                        end else begin
                            st_r <= TWCW_LOW;
                        end
                    end
                end
                TWCW_END: begin
                    // Raise strobe after the last MSB and a hold time.
                    cnt_r <= cnt_r + TWCW_RCNT_W'(1);
                    if (cnt_r == TWCW_RCNT_W'(TWCW_HALF_DIV - 1)) begin
                        sl_r  <= 1'b1; // [RL4]
                        cnt_r <= '0;
                        st_r  <= TWCW_IDLE;
                    end
                end
                default: st_r <= TWCW_IDLE;
            endcase
        end
    end

endmodule : twcw_host

// file: twcw_link_assertions.sv
`timescale 1ns/1ps
// Watches the serial link in the host clock domain.
module twcw_link_assertions
    import twcw_pkg::*;
(
    // Host clock and reset.
    input logic clock,
    input logic rst,
    // Link wires.
    input logic shift_clk,
    input logic load_strobe_n,
    input logic serial_data_in,
    input logic reg_rst_n
);
    logic [15:0] gap_r;
    logic [15:0] low_r;
    logic [7:0]  rises_r;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Cycles since the last shift clock or strobe change, so edge spacing can be checked.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) gap_r <= '0;
        else if ($changed(shift_clk) || $changed(load_strobe_n)) gap_r <= '0;
        else gap_r <= gap_r + 16'h0001;
    end
    // Length of the current register reset pulse.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) low_r <= '0;
        else if (reg_rst_n) low_r <= '0;
        else low_r <= low_r + 16'h0001;
    end
    // Shift clock rises inside the current frame.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) rises_r <= '0;
        else if ($fell(load_strobe_n)) rises_r <= '0;
        else if ($rose(shift_clk) && !load_strobe_n) rises_r <= rises_r + 8'h01;
    end
    sequence s_open;
        $fell(load_strobe_n);
    endsequence
    sequence s_quiet;
        !shift_clk [*8];
    endsequence
    AST_SCK_HALF: assert property (($changed(shift_clk) || $rose(load_strobe_n))
        |-> gap_r == 16'(TWCW_HALF_DIV - 1)) else $error("bad edge spacing");
    AST_SCK_IDLE: assert property (load_strobe_n |-> !shift_clk)
        else $error("clock moves outside frame");
    AST_WHOLE_BYTES: assert property ($rose(load_strobe_n)
        |-> rises_r[2:0] == 3'h0 && rises_r != 8'h00) else $error("partial byte");
    AST_MAX_BYTES: assert property (rises_r <= 8'(TWCW_NUM_REGS * 8))
        else $error("too many bits");
    AST_SEL_FIRST: assert property ($rose(shift_clk) && rises_r == 8'h00
        |-> serial_data_in) else $error("variant bit low");
    AST_DATA_HOLD: assert property (shift_clk && $past(shift_clk)
        |-> $stable(serial_data_in)) else $error("data moved while clock high");
    AST_SETUP: assert property (s_open |=> s_quiet) else $error("strobe setup short");
    AST_RESET_WIDTH: assert property ($rose(reg_rst_n)
        |-> low_r >= 16'(TWCW_RST_CYC - 1)) else $error("reset pulse short");
    AST_RESET_QUIET: assert property (!reg_rst_n |-> load_strobe_n && !shift_clk)
        else $error("link active in reset");
endmodule : twcw_link_assertions

// file: three_wire_config_write_port_tb_top.sv
`timescale 1ns/1ps
module three_wire_config_write_port_tb_top import twcw_pkg::*;;
    logic       clock, rst, cmd_reset, cmd_write, busy_r;
    logic [5:0] cmd_nbytes;
    logic [7:0] cmd_data [TWCW_NUM_REGS];
    logic [7:0] q_a [TWCW_NUM_REGS];
    logic [7:0] q_b [TWCW_NUM_REGS];
    logic [7:0] exp_a [TWCW_NUM_REGS];
    int         error_cnt, n_tests, k;
    twcw_if lk_a ();
    twcw_if lk_b ();
    twcw_host u_twcw_host (.clock(clock), .rst(rst), .link(lk_a.host), .cmd_reset(cmd_reset),
        .cmd_write(cmd_write), .cmd_nbytes(cmd_nbytes), .cmd_data(cmd_data), .busy_r(busy_r));
    twcw_dev u_twcw_dev (.link(lk_a.dev), .reg_q(q_a));
    twcw_dev u_twcw_dev_b (.link(lk_b.dev), .reg_q(q_b));
    twcw_link_assertions u_twcw_link_assertions (.clock(clock), .rst(rst),
        .shift_clk(lk_a.shift_clk), .load_strobe_n(lk_a.load_strobe_n),
        .serial_data_in(lk_a.serial_data_in), .reg_rst_n(lk_a.reg_rst_n));
    // Host clock.
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    task check(input logic [7:0] got, input logic [7:0] want);
        n_tests++;
        if (got !== want) begin
            error_cnt++;
            $display("wrong value at %0t: got %h want %h", $time, got, want);
        end
    endtask : check
    task report_and_stop;
        $display("compares %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop
    task check_a;
        for (int i = 0; i < TWCW_NUM_REGS; i++) check(q_a[i], exp_a[i]);
    endtask : check_a
    // Waits for the host to go idle, giving up after a bounded count.
    task wait_idle;
        repeat (3) @(posedge clock);
        for (int i = 0; i < 4000 && busy_r !== 1'b0; i++) @(posedge clock);
        if (busy_r !== 1'b0) begin
            error_cnt++;
            $display("wrong value at %0t: host stuck busy", $time);
            report_and_stop();
        end
    endtask : wait_idle
    task host_cmd(input logic wr, input int n);
        cmd_nbytes <= 6'(n);
        if (wr) cmd_write <= 1'b1;
        else cmd_reset <= 1'b1;
        @(posedge clock);
        cmd_write <= 1'b0;
        cmd_reset <= 1'b0;
        for (int i = 0; i < TWCW_NUM_REGS; i++) begin
            if (!wr) exp_a[i] = (i == 0) ? TWCW_VMC_RST : TWCW_REG_RST;
            else if (i < n) exp_a[i] = cmd_data[i] | 8'(i == 0);
        end
        wait_idle();
    endtask : host_cmd
    // Bit-bangs a frame on the second link, LSB first, three clocks per half period.
    task raw_frame(input logic [15:0] bits, input int nbits);
        lk_b.load_strobe_n <= 1'b0;
        for (int i = 0; i < nbits; i++) begin
            lk_b.serial_data_in <= bits[i];
            repeat (3) @(posedge clock);
            lk_b.shift_clk <= 1'b1;
            repeat (3) @(posedge clock);
            lk_b.shift_clk <= 1'b0;
        end
        repeat (3) @(posedge clock);
        lk_b.load_strobe_n <= 1'b1;
        lk_b.serial_data_in <= ~bits[nbits-1];
        repeat (3) @(posedge clock);
    endtask : raw_frame
    // Main sequence.
    initial begin
        {rst, cmd_reset, cmd_write, cmd_nbytes, error_cnt, n_tests} = '0;
        rst = 1'b1;
        cmd_data = '{default: 8'h00};
        {lk_b.shift_clk, lk_b.serial_data_in, lk_b.reg_rst_n} = 3'h0;
        lk_b.load_strobe_n = 1'b1;
        exp_a = '{default: TWCW_REG_RST};
        exp_a[0] = TWCW_VMC_RST;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        repeat (TWCW_RST_CYC) @(posedge clock);
        lk_b.reg_rst_n <= 1'b1;
        wait_idle();
        check_a();
        check(q_b[0], TWCW_VMC_RST);
        for (k = 0; k < 7; k++) cmd_data[k] <= 8'hA4 + 8'(k * 19);
        host_cmd(1'b1, 7);
        check_a();
        for (k = 0; k < 7; k++) cmd_data[k] <= 8'h5A ^ 8'(k);
        host_cmd(1'b1, 2);
        check_a();
        for (k = 0; k < 7; k++) cmd_data[k] <= 8'hC3 - 8'(k);
        host_cmd(1'b1, 9);
        check_a();
        host_cmd(1'b0, 0);
        check_a();
        raw_frame(16'h00F2, 8);
        check(q_b[0], TWCW_VMC_RST);
        raw_frame(16'h3CF1, 16);
        check(q_b[0], 8'hF1);
        check(q_b[1], 8'h3C);
        raw_frame(16'h0F0F, 12);
        check(q_b[0], 8'hF1);
        check(q_b[1], 8'h3C);
        for (k = 0; k < 6; k++) begin
            lk_b.shift_clk <= ~lk_b.shift_clk;
            lk_b.serial_data_in <= 1'(k);
            repeat (2) @(posedge clock);
        end
        raw_frame(16'h0081, 8);
        check(q_b[0], 8'h81);
        report_and_stop();
    end
endmodule : three_wire_config_write_port_tb_top
